// file: rtl/psm_pkg.sv
`default_nettype none
package psm_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam int            ADDR_W        = 8;
	localparam int            DATA_W        = 32;
	localparam logic [7:0]    OFF_MODE_CTRL = 8'h00;
	localparam logic [7:0]    OFF_WAKE_EN   = 8'h04;
	localparam logic [7:0]    OFF_WAKE_SRC  = 8'h08;
	localparam logic [7:0]    OFF_RST_ORIG  = 8'h0c;
	localparam logic [7:0]    OFF_BKP_WAKE  = 8'h10;
	localparam logic [7:0]    OFF_HSB_MASK  = 8'h14;
	localparam logic [7:0]    OFF_PB_MASK   = 8'h18;
	localparam logic [7:0]    OFF_STATUS    = 8'h1c;

	// ****************************************
	// power_mode_control fields
	// ****************************************
	localparam int            F_DEPTH_LO    = 0;
	localparam int            F_DEPTH_HI    = 1;
	localparam int            F_RETENTION   = 2;
	localparam int            F_BACKUP      = 3;
	localparam int            F_SLOW_SEL    = 4;
	localparam int            F_SLOW_XTAL   = 5;
	localparam int            F_SLOW_RC     = 6;
	localparam int            F_WAKE_IRQ    = 7;
	localparam int            F_RUN_LO      = 8;
	localparam int            F_RUN_HI      = 9;

	// ****************************************
	// Encodings and reset values
	// ****************************************
	localparam logic [1:0]    DEPTH_CPU     = 2'h0;
	localparam logic [1:0]    DEPTH_HSB     = 2'h1;
	localparam logic [1:0]    DEPTH_PB      = 2'h2;
	localparam logic [1:0]    DEFAULT_RUN   = 2'h0;
	localparam int            RO_W          = 6;
	localparam int            RO_POWER_UP   = 0;
	localparam int            RO_IO_BOD     = 1;
	localparam int            RO_CORE_BOD   = 2;
	localparam int            RO_WDT        = 3;
	localparam int            RO_PIN        = 4;
	localparam int            RO_BACKUP     = 5;
	localparam int            BW_W          = 5;
	localparam int            BW_EXT        = 0;
	localparam int            BW_IO_BOD     = 1;
	localparam int            BW_CORE_BOD   = 2;
	localparam int            BW_RTC        = 3;
	localparam int            BW_WDT        = 4;

	typedef enum logic [2:0] {
		PSM_RUN,
		PSM_SLEEP,
		PSM_WAIT,
		PSM_RETAIN,
		PSM_BACKUP,
		PSM_CORE_UP
	} psm_mode_t;

endpackage
`default_nettype wire

// file: rtl/psm_clk_if.sv
`timescale 1ns/1ps
`default_nettype none
interface psm_clk_if #(
	parameter int NHSB = 8,
	parameter int NPB  = 16
);
	psm_pkg::psm_mode_t mode;
	logic [1:0]         depth;
	logic [NHSB-1:0]    hsb_mask;
	logic [NPB-1:0]     pb_mask;
	logic               cpu_en;
	logic [NHSB-1:0]    hsb_en;
	logic [NPB-1:0]     pb_en;
	logic               generic_clock_en;
	logic               fast_en;
	logic               system_rc_oscillator_en;

	modport seq  (output mode, depth, hsb_mask, pb_mask,
		input cpu_en, hsb_en, pb_en, generic_clock_en, fast_en, system_rc_oscillator_en);
	modport gate (input mode, depth, hsb_mask, pb_mask,
		output cpu_en, hsb_en, pb_en, generic_clock_en, fast_en, system_rc_oscillator_en);
endinterface
`default_nettype wire

// file: rtl/psm_clock_gate.sv
`timescale 1ns/1ps
`default_nettype none
module psm_clock_gate (
	psm_clk_if.gate g
);
	// ****************************************
	// Clock enables per mode and sleep depth
	// ****************************************
	always_comb begin
		g.cpu_en   = 1'b0;
		g.hsb_en   = '0;
		g.pb_en    = '0;
		g.generic_clock_en  = 1'b0;
		g.fast_en  = 1'b0;
		g.system_rc_oscillator_en = 1'b0;
		case (g.mode)
			psm_pkg::PSM_RUN: begin
				g.cpu_en   = 1'b1;
				g.hsb_en   = g.hsb_mask;
				g.pb_en    = g.pb_mask;
				g.generic_clock_en  = 1'b1;
				g.fast_en  = 1'b1;
				g.system_rc_oscillator_en = 1'b1;
			end
			psm_pkg::PSM_SLEEP: begin
				// Depth overrides the masks, cumulatively
				g.hsb_en   = (g.depth == psm_pkg::DEPTH_CPU) ? g.hsb_mask : '0;
				g.pb_en    = (g.depth <= psm_pkg::DEPTH_HSB) ? g.pb_mask : '0;
				g.generic_clock_en  = (g.depth <= psm_pkg::DEPTH_HSB);
				g.fast_en  = (g.depth <= psm_pkg::DEPTH_PB);
				g.system_rc_oscillator_en = 1'b1;
			end
			psm_pkg::PSM_CORE_UP: begin
				// System RC clock and the masked HSB and PB clocks while the core is held in reset
				g.hsb_en   = g.hsb_mask;
				g.pb_en    = g.pb_mask;
				g.system_rc_oscillator_en = 1'b1;
			end
			default: begin
				// Wait, retention and backup: every core clock stopped
				g.system_rc_oscillator_en = 1'b0;
			end
		endcase
	end
endmodule
`default_nettype wire

// file: rtl/psm_sequencer.sv
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module psm_sequencer #(
	parameter int              NHSB          = 8,
	parameter int              NPB           = 16,
	parameter int              NAW           = 8,
	parameter logic [NHSB-1:0] HSB_MASK_RST  = '1,
	parameter logic [NPB-1:0]  PB_MASK_RST   = '0
) (
	// Clock and reset
	input  wire logic                       core_clk_in,
	input  wire logic                       rst_in,
	// Register port
	input  wire logic [psm_pkg::ADDR_W-1:0] reg_addr_in,
	input  wire logic [psm_pkg::DATA_W-1:0] reg_wdata_in,
	input  wire logic                       reg_wr_in,
	input  wire logic                       reg_rd_in,
	output logic      [psm_pkg::DATA_W-1:0] reg_rdata_out,
	// Processor core
	input  wire logic                       wfi_in,
	input  wire logic                       isr_exit_lowest_in,
	input  wire logic                       deep_sleep_select_in,
	input  wire logic                       sleep_on_isr_exit_in,
	// Pending interrupts grouped by the clock of their source
	input  wire logic                       irq_hsb_pending_in,
	input  wire logic                       irq_pb_pending_in,
	input  wire logic                       irq_fast_pending_in,
	input  wire logic                       irq_slow_pending_in,
	// Asynchronous wake sources
	input  wire logic [NAW-1:0]             async_wake_in,
	input  wire logic                       ext_int_wake_in,
	input  wire logic                       rtc_wake_in,
	input  wire logic                       io_bod_irq_in,
	input  wire logic                       core_bod_irq_in,
	input  wire logic                       wdt_irq_in,
	// Reset sources
	input  wire logic                       io_bod_rst_in,
	input  wire logic                       core_bod_rst_in,
	input  wire logic                       wdt_rst_in,
	input  wire logic                       ext_rst_pin_in,
	// Core supply
	input  wire logic                       core_supply_ok_in,
	output logic                            core_power_on_out,
	output logic                            core_reset_out,
	output logic                            io_hold_out,
	// Clock enables
	output logic                            cpu_clk_en_out,
	output logic      [NHSB-1:0]            hsb_clk_en_out,
	output logic      [NPB-1:0]             pb_clk_en_out,
	output logic                            generic_clock_en_out,
	output logic                            fast_osc_en_out,
	output logic                            system_rc_oscillator_en_out,
	output logic                            slow_xtal_en_out,
	output logic                            slow_rc_en_out,
	output logic                            slow_clock_source_select_out,
	// Status
	output logic                            wake_irq_out,
	output logic      [1:0]                 run_state_out,
	output logic      [2:0]                 mode_out
);

	localparam int WSF_W = NAW + 2;

	typedef struct packed {
		psm_pkg::psm_mode_t          mode;
		logic [1:0]                  depth;
		logic                        retention_select;
		logic                        backup_select;
		logic                        slow_sel;
		logic                        slow_xtal_en;
		logic                        slow_rc_en;
		logic                        wake_irq_en;
		logic [1:0]                  run_state;
		logic [1:0]                  saved_run;
		logic                        core_wake;
		logic [NAW-1:0]              async_wake_enable;
		logic [WSF_W-1:0]            wake_source_flags;
		logic [psm_pkg::RO_W-1:0]    reset_origin_flags;
		logic [psm_pkg::BW_W-1:0]    backup_wake_source_flags;
		logic [NHSB-1:0]             hsb_mask;
		logic [NPB-1:0]              pb_mask;
		logic [psm_pkg::DATA_W-1:0]  rdata;
	} psm_state_t;

	typedef logic [psm_pkg::DATA_W-1:0] psm_word_t;

	psm_state_t s_r;
	psm_state_t s_nxt;

	psm_clk_if #(.NHSB(NHSB), .NPB(NPB)) clk_bus ();

	// ****************************************
	// Combined events
	// ****************************************
	logic                         any_rst;
	logic                         enter_req;
	logic                         sleep_wake;
	logic [WSF_W-1:0]             async_hits;
	logic [psm_pkg::BW_W-1:0]     backup_hits;
	logic [psm_pkg::RO_W-1:0]     rst_hits;
	logic [psm_pkg::DATA_W-1:0]   ctrl_word;
	logic [psm_pkg::DATA_W-1:0]   wd;

	assign wd        = reg_wdata_in;
	assign any_rst   = io_bod_rst_in | core_bod_rst_in | wdt_rst_in | ext_rst_pin_in;
	assign enter_req = wfi_in | (isr_exit_lowest_in & sleep_on_isr_exit_in);

	// Only sources whose clock survives the depth may wake
	assign sleep_wake = irq_slow_pending_in
		| (irq_fast_pending_in & (s_r.depth <= psm_pkg::DEPTH_PB))
		| (irq_pb_pending_in & (s_r.depth <= psm_pkg::DEPTH_HSB))
		| (irq_hsb_pending_in & (s_r.depth == psm_pkg::DEPTH_CPU));

	// External line and counter bypass the enable register
	assign async_hits = {rtc_wake_in, ext_int_wake_in, async_wake_in & s_r.async_wake_enable};

	always_comb begin
		backup_hits                        = '0;
		backup_hits[psm_pkg::BW_EXT]       = ext_int_wake_in;
		backup_hits[psm_pkg::BW_IO_BOD]    = io_bod_irq_in;
		backup_hits[psm_pkg::BW_CORE_BOD]  = core_bod_irq_in;
		backup_hits[psm_pkg::BW_RTC]       = rtc_wake_in;
		backup_hits[psm_pkg::BW_WDT]       = wdt_irq_in;
		rst_hits                           = '0;
		rst_hits[psm_pkg::RO_IO_BOD]       = io_bod_rst_in;
		rst_hits[psm_pkg::RO_CORE_BOD]     = core_bod_rst_in;
		rst_hits[psm_pkg::RO_WDT]          = wdt_rst_in;
		rst_hits[psm_pkg::RO_PIN]          = ext_rst_pin_in;
	end

	always_comb begin
		ctrl_word                                        = '0;
		ctrl_word[psm_pkg::F_DEPTH_HI:psm_pkg::F_DEPTH_LO] = s_r.depth;
		ctrl_word[psm_pkg::F_RETENTION]                  = s_r.retention_select;
		ctrl_word[psm_pkg::F_BACKUP]                     = s_r.backup_select;
		ctrl_word[psm_pkg::F_SLOW_SEL]                   = s_r.slow_sel;
		ctrl_word[psm_pkg::F_SLOW_XTAL]                  = s_r.slow_xtal_en;
		ctrl_word[psm_pkg::F_SLOW_RC]                    = s_r.slow_rc_en;
		ctrl_word[psm_pkg::F_WAKE_IRQ]                   = s_r.wake_irq_en;
		ctrl_word[psm_pkg::F_RUN_HI:psm_pkg::F_RUN_LO]     = s_r.run_state;
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		s_nxt       = s_r;
		s_nxt.rdata = '0;

		// Register reads, answered in the following cycle
		if (reg_rd_in) begin
			case (reg_addr_in)
				psm_pkg::OFF_MODE_CTRL: s_nxt.rdata = ctrl_word;
				psm_pkg::OFF_WAKE_EN:   s_nxt.rdata = psm_word_t'(s_r.async_wake_enable);
				psm_pkg::OFF_WAKE_SRC:  s_nxt.rdata = psm_word_t'(s_r.wake_source_flags);
				psm_pkg::OFF_RST_ORIG:  s_nxt.rdata = psm_word_t'(s_r.reset_origin_flags);
				psm_pkg::OFF_BKP_WAKE:  s_nxt.rdata = psm_word_t'(s_r.backup_wake_source_flags);
				psm_pkg::OFF_HSB_MASK:  s_nxt.rdata = psm_word_t'(s_r.hsb_mask);
				psm_pkg::OFF_PB_MASK:   s_nxt.rdata = psm_word_t'(s_r.pb_mask);
				psm_pkg::OFF_STATUS:    s_nxt.rdata = psm_word_t'(s_r.mode);
				default:                s_nxt.rdata = '0;
			endcase
		end

		// Register writes; the core only runs software in the run mode
		if (reg_wr_in && (s_r.mode == psm_pkg::PSM_RUN)) begin
			case (reg_addr_in)
				psm_pkg::OFF_MODE_CTRL: begin
					s_nxt.depth            = wd[psm_pkg::F_DEPTH_HI:psm_pkg::F_DEPTH_LO];
					s_nxt.retention_select = wd[psm_pkg::F_RETENTION];
					s_nxt.backup_select    = wd[psm_pkg::F_BACKUP];
					s_nxt.slow_sel         = wd[psm_pkg::F_SLOW_SEL];
					s_nxt.slow_xtal_en     = wd[psm_pkg::F_SLOW_XTAL];
					s_nxt.slow_rc_en       = wd[psm_pkg::F_SLOW_RC];
					s_nxt.wake_irq_en      = wd[psm_pkg::F_WAKE_IRQ];
					s_nxt.run_state        = wd[psm_pkg::F_RUN_HI:psm_pkg::F_RUN_LO];
				end
				psm_pkg::OFF_WAKE_EN: begin
					s_nxt.async_wake_enable = wd[NAW-1:0];
				end
				psm_pkg::OFF_WAKE_SRC: begin
					s_nxt.wake_source_flags = s_r.wake_source_flags & ~wd[WSF_W-1:0];
				end
				psm_pkg::OFF_RST_ORIG: begin
					s_nxt.reset_origin_flags = s_r.reset_origin_flags & ~wd[psm_pkg::RO_W-1:0];
				end
				psm_pkg::OFF_BKP_WAKE: begin
					s_nxt.backup_wake_source_flags =
						s_r.backup_wake_source_flags & ~wd[psm_pkg::BW_W-1:0];
				end
				psm_pkg::OFF_HSB_MASK: begin
					s_nxt.hsb_mask = wd[NHSB-1:0];
				end
				psm_pkg::OFF_PB_MASK: begin
					s_nxt.pb_mask = wd[NPB-1:0];
				end
				default: begin
					s_nxt.rdata = s_nxt.rdata;
				end
			endcase
		end

		// Mode sequencing; flag sets below come after clears so a set wins
		case (s_r.mode)
			psm_pkg::PSM_RUN: begin
				if (enter_req) begin
					s_nxt.saved_run = s_r.run_state;
					if (!deep_sleep_select_in) begin
						s_nxt.mode = psm_pkg::PSM_SLEEP;
					end else if (s_r.backup_select) begin
						s_nxt.mode = psm_pkg::PSM_BACKUP;
					end else if (s_r.retention_select) begin
						s_nxt.mode = psm_pkg::PSM_RETAIN;
					end else begin
						s_nxt.mode = psm_pkg::PSM_WAIT;
					end
				end
			end
			psm_pkg::PSM_SLEEP: begin
				if (sleep_wake) begin
					s_nxt.mode      = psm_pkg::PSM_RUN;
					s_nxt.run_state = s_r.saved_run;
				end
			end
			psm_pkg::PSM_WAIT, psm_pkg::PSM_RETAIN: begin
				if (|async_hits) begin
					s_nxt.mode              = psm_pkg::PSM_RUN;
					s_nxt.run_state         = s_r.saved_run;
					s_nxt.wake_source_flags = s_nxt.wake_source_flags | async_hits;
				end
			end
			psm_pkg::PSM_BACKUP: begin
				if (|backup_hits) begin
					s_nxt.mode      = psm_pkg::PSM_CORE_UP;
					s_nxt.core_wake = 1'b1;
					s_nxt.backup_wake_source_flags =
						s_nxt.backup_wake_source_flags | backup_hits;
					// Core domain contents are lost, backup domain kept
					s_nxt.async_wake_enable = '0;
					s_nxt.wake_source_flags = '0;
					s_nxt.hsb_mask          = HSB_MASK_RST;
					s_nxt.pb_mask           = PB_MASK_RST;
				end
			end
			psm_pkg::PSM_CORE_UP: begin
				if (core_supply_ok_in) begin
					s_nxt.mode      = psm_pkg::PSM_RUN;
					s_nxt.core_wake = 1'b0;
					if (s_r.core_wake) begin
						s_nxt.run_state = s_r.saved_run;
						s_nxt.reset_origin_flags[psm_pkg::RO_BACKUP] = 1'b1;
					end
				end
			end
			default: begin
				s_nxt.mode = psm_pkg::PSM_CORE_UP;
			end
		endcase

		// A reset source overrides the mode sequencing and forgets the old run state
		if (any_rst) begin
			s_nxt.mode               = psm_pkg::PSM_CORE_UP;
			s_nxt.core_wake          = 1'b0;
			s_nxt.run_state          = psm_pkg::DEFAULT_RUN;
			s_nxt.async_wake_enable  = '0;
			s_nxt.wake_source_flags  = '0;
			s_nxt.hsb_mask           = HSB_MASK_RST;
			s_nxt.pb_mask            = PB_MASK_RST;
			s_nxt.reset_origin_flags = s_nxt.reset_origin_flags | rst_hits;
		end
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			s_r                                          <= '0;
			s_r.mode                                     <= psm_pkg::PSM_CORE_UP;
			s_r.run_state                                <= psm_pkg::DEFAULT_RUN;
			s_r.saved_run                                <= psm_pkg::DEFAULT_RUN;
			s_r.hsb_mask                                 <= HSB_MASK_RST;
			s_r.pb_mask                                  <= PB_MASK_RST;
			s_r.reset_origin_flags[psm_pkg::RO_POWER_UP] <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ****************************************
	// Clock gating and outputs
	// ****************************************
	assign clk_bus.mode     = s_r.mode;
	assign clk_bus.depth    = s_r.depth;
	assign clk_bus.hsb_mask = s_r.hsb_mask;
	assign clk_bus.pb_mask  = s_r.pb_mask;

	psm_clock_gate u_gate (
		.g (clk_bus.gate)
	);

	assign cpu_clk_en_out   = clk_bus.cpu_en;
	assign hsb_clk_en_out   = clk_bus.hsb_en;
	assign pb_clk_en_out    = clk_bus.pb_en;
	assign generic_clock_en_out      = clk_bus.generic_clock_en;
	assign fast_osc_en_out  = clk_bus.fast_en;
	assign system_rc_oscillator_en_out     = clk_bus.system_rc_oscillator_en;

	// Slow oscillators follow their enables through every mode
	assign slow_xtal_en_out             = s_r.slow_xtal_en;
	assign slow_rc_en_out               = s_r.slow_rc_en;
	assign slow_clock_source_select_out = s_r.slow_sel;

	assign core_power_on_out = (s_r.mode != psm_pkg::PSM_BACKUP);
	assign core_reset_out    = (s_r.mode == psm_pkg::PSM_CORE_UP);
	assign io_hold_out       = (s_r.mode != psm_pkg::PSM_RUN);

	assign wake_irq_out  = s_r.wake_irq_en & (|s_r.wake_source_flags);
	assign run_state_out = s_r.run_state;
	assign mode_out      = s_r.mode;
	assign reg_rdata_out = s_r.rdata;

endmodule
`default_nettype wire

// file: verif/psm_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module psm_core_model (
	// Clock
	input  wire logic clk_in,
	// Requests from the test sequence
	input  wire logic req_in,
	input  wire logic deep_in,
	input  wire logic soe_in,
	// Core side of the sequencer
	output logic      wfi_out,
	output logic      isr_exit_out,
	output logic      deep_sleep_out,
	output logic      soe_out
);
	// ****************************************
	// Core issuing sleep after selects are settled
	// ****************************************
	// Selects are levels held until the next request; no event processing is issued
	assign deep_sleep_out = deep_in;
	assign soe_out        = soe_in;
	always @(posedge clk_in) begin
		wfi_out      <= req_in && !soe_in;
		isr_exit_out <= req_in && soe_in;
	end
endmodule
`default_nettype wire

// file: verif/psm_sequencer_properties.sv
`timescale 1ns/1ps
`default_nettype none
module psm_sequencer_properties #(
	parameter int NHSB = 8,
	parameter int NPB  = 16
) (
	input wire logic            core_clk_in,
	input wire logic            rst_in,
	input wire logic            isr_exit_lowest_in,
	input wire logic            deep_sleep_select_in,
	input wire logic            sleep_on_isr_exit_in,
	input wire logic            irq_slow_pending_in,
	input wire logic            ext_int_wake_in,
	input wire logic            io_bod_rst_in,
	input wire logic            core_bod_rst_in,
	input wire logic            wdt_rst_in,
	input wire logic            ext_rst_pin_in,
	input wire logic            core_supply_ok_in,
	input wire logic            core_power_on_out,
	input wire logic            core_reset_out,
	input wire logic            io_hold_out,
	input wire logic            cpu_clk_en_out,
	input wire logic [NHSB-1:0] hsb_clk_en_out,
	input wire logic [NPB-1:0]  pb_clk_en_out,
	input wire logic            generic_clock_en_out,
	input wire logic            fast_osc_en_out,
	input wire logic            system_rc_oscillator_en_out,
	input wire logic [1:0]      run_state_out,
	input wire logic [2:0]      mode_out
);
	wire logic any_rst = io_bod_rst_in | core_bod_rst_in | wdt_rst_in | ext_rst_pin_in;
	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (rst_in);
	// ****************************************
	// Mode and clock relations
	// ****************************************
	AST_RESET_CORE: assert property (any_rst
		|=> mode_out == 3'h5 && run_state_out == 2'h0)
		else $error("reset source did not force core restart");
	AST_CORE_RELEASE: assert property (mode_out == 3'h5 && core_supply_ok_in
		&& !any_rst |=> mode_out == 3'h0 && !core_reset_out)
		else $error("core reset not released on good supply");
	AST_HOLD_SUPPLY: assert property (mode_out == 3'h5 && !core_supply_ok_in
		|=> mode_out == 3'h5 && core_reset_out)
		else $error("core reset released without good supply");
	AST_IO_HOLD: assert property (io_hold_out == (mode_out != 3'h0))
		else $error("pad hold mismatch");
	AST_SLEEP_CLOCKS: assert property (mode_out == 3'h1
		|-> !cpu_clk_en_out && system_rc_oscillator_en_out)
		else $error("sleep clock enables wrong");
	AST_DEEP_CLOCKS: assert property (mode_out inside {3'h2, 3'h3, 3'h4}
		|-> hsb_clk_en_out == '0 && pb_clk_en_out == '0
		&& !(cpu_clk_en_out | generic_clock_en_out | fast_osc_en_out | system_rc_oscillator_en_out))
		else $error("clock running in deep mode");
	AST_BACKUP_POWER: assert property (core_power_on_out == (mode_out != 3'h4))
		else $error("core power mismatch");
	AST_SOE_ENTRY: assert property (mode_out == 3'h0 && isr_exit_lowest_in
		&& sleep_on_isr_exit_in && !deep_sleep_select_in && !any_rst |=> mode_out == 3'h1)
		else $error("sleep on handler exit missed");
	AST_SLEEP_WAKE: assert property (mode_out == 3'h1 && irq_slow_pending_in
		&& !any_rst |=> mode_out == 3'h0)
		else $error("sleep not ended by interrupt");
	AST_WAIT_WAKE: assert property (mode_out inside {3'h2, 3'h3} && ext_int_wake_in
		&& !any_rst |=> mode_out == 3'h0)
		else $error("wait not ended by wake event");
	AST_BACKUP_WAKE: assert property (mode_out == 3'h4 && ext_int_wake_in
		&& !any_rst |=> mode_out == 3'h5 && core_reset_out)
		else $error("backup not ended by wake event");
	COV_SLEEP: cover property (mode_out == 3'h0 ##1 mode_out == 3'h1);
	COV_BACKUP_WAKE: cover property (mode_out == 3'h4 ##1 mode_out == 3'h5);
	COV_RESET_EXIT: cover property (any_rst ##1 mode_out == 3'h5);
endmodule
bind psm_sequencer psm_sequencer_properties #(.NHSB(NHSB), .NPB(NPB)) u_props (
	.core_clk_in, .rst_in, .isr_exit_lowest_in, .deep_sleep_select_in, .sleep_on_isr_exit_in,
	.irq_slow_pending_in, .ext_int_wake_in, .io_bod_rst_in, .core_bod_rst_in, .wdt_rst_in,
	.ext_rst_pin_in, .core_supply_ok_in, .core_power_on_out, .core_reset_out, .io_hold_out,
	.cpu_clk_en_out, .hsb_clk_en_out, .pb_clk_en_out, .generic_clock_en_out, .fast_osc_en_out,
	.system_rc_oscillator_en_out, .run_state_out, .mode_out);
`default_nettype wire

// file: verif/power_save_mode_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module power_save_mode_sequencer_tb;
	logic        core_clk_in = 1'b0, rst_in = 1'b1, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
	logic [7:0]  reg_addr_in = 8'h00, aw = 8'h00;
	logic [31:0] reg_wdata_in = 32'h0;
	logic        req = 1'b0, deep = 1'b0, soe = 1'b0, core_supply_ok_in = 1'b1;
	logic [3:0]  irq = 4'h0, rs = 4'h0;
	logic [4:0]  bk = 5'h0;
	int          error_cnt = 0, checked = 0, cyc = 0;
	wire logic irq_hsb_pending_in = irq[0], irq_pb_pending_in = irq[1];
	wire logic irq_fast_pending_in = irq[2], irq_slow_pending_in = irq[3];
	wire logic ext_int_wake_in = bk[0], io_bod_irq_in = bk[1], core_bod_irq_in = bk[2];
	wire logic rtc_wake_in = bk[3], wdt_irq_in = bk[4];
	wire logic io_bod_rst_in = rs[0], core_bod_rst_in = rs[1], wdt_rst_in = rs[2];
	wire logic ext_rst_pin_in = rs[3];
	wire logic wfi_in, isr_exit_lowest_in, deep_sleep_select_in, sleep_on_isr_exit_in;
	wire logic core_power_on_out, core_reset_out, io_hold_out, cpu_clk_en_out, generic_clock_en_out;
	wire logic fast_osc_en_out, system_rc_oscillator_en_out, slow_xtal_en_out, slow_rc_en_out, wake_irq_out;
	wire logic slow_clock_source_select_out;
	wire logic [7:0]  hsb_clk_en_out;
	wire logic [15:0] pb_clk_en_out;
	wire logic [31:0] reg_rdata_out;
	wire logic [1:0]  run_state_out;
	wire logic [2:0]  mode_out;

	psm_core_model core (.clk_in(core_clk_in), .req_in(req), .deep_in(deep), .soe_in(soe),
		.wfi_out(wfi_in), .isr_exit_out(isr_exit_lowest_in),
		.deep_sleep_out(deep_sleep_select_in), .soe_out(sleep_on_isr_exit_in));
	psm_sequencer dut (.core_clk_in, .rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
		.reg_rdata_out, .wfi_in, .isr_exit_lowest_in, .deep_sleep_select_in, .sleep_on_isr_exit_in,
		.irq_hsb_pending_in, .irq_pb_pending_in, .irq_fast_pending_in, .irq_slow_pending_in,
		.async_wake_in(aw), .ext_int_wake_in, .rtc_wake_in, .io_bod_irq_in, .core_bod_irq_in,
		.wdt_irq_in, .io_bod_rst_in, .core_bod_rst_in, .wdt_rst_in, .ext_rst_pin_in,
		.core_supply_ok_in, .core_power_on_out, .core_reset_out, .io_hold_out, .cpu_clk_en_out,
		.hsb_clk_en_out, .pb_clk_en_out, .generic_clock_en_out, .fast_osc_en_out, .system_rc_oscillator_en_out,
		.slow_xtal_en_out, .slow_rc_en_out, .slow_clock_source_select_out, .wake_irq_out,
		.run_state_out, .mode_out);

	always #25 core_clk_in = ~core_clk_in;
	always @(posedge core_clk_in) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			tally_and_finish();
		end
	end
	// ****************************************
	// Access and compare tasks
	// ****************************************
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'b1;
		@(posedge core_clk_in);
		reg_wr_in <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge core_clk_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge core_clk_in);
		reg_rd_in <= 1'b0;
		#1 chk("rdata", exp, reg_rdata_out);
	endtask
	task automatic go(input logic d, input logic s);
		@(posedge core_clk_in);
		req <= 1'b1;
		deep <= d;
		soe <= s;
		@(posedge core_clk_in);
		req <= 1'b0;
	endtask
	task automatic wmode(input logic [2:0] exp);
		int n;
		n = 0;
		while (mode_out !== exp && n < 20) begin
			@(posedge core_clk_in);
			#1 n++;
		end
		chk("mode", {29'h0, exp}, {29'h0, mode_out});
	endtask
	task automatic tally_and_finish();
		$display("checked %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// ****************************************
	// Test sequence
	// ****************************************
	initial begin
		repeat (10) @(posedge core_clk_in);
		rst_in <= 1'b0;
		wmode(3'h0);
		chk("run_clk", 32'h3, {30'h0, cpu_clk_en_out, system_rc_oscillator_en_out});
		rd(8'h0c, 32'h1);
		rd(8'h20, 32'h0);
		wr(8'h0c, 32'h3f);
		$display("test reset done");
		wr(8'h18, 32'hffff);
		for (int d = 0; d < 4; d++) begin
			wr(8'h00, 32'h200 | d);
			go(1'b0, d == 3);
			wmode(3'h1);
			chk("hsb_en", d ? 0 : 32'hff, {24'h0, hsb_clk_en_out});
			chk("pb_en", d > 1 ? 0 : 32'hffff, {16'h0, pb_clk_en_out});
			chk("generic_clock_fast", {d < 2, d < 3}, {generic_clock_en_out, fast_osc_en_out});
			@(posedge core_clk_in);
			irq <= 4'h4;
			repeat (3) @(posedge core_clk_in);
			irq <= 4'h8;
			#1 chk("fast_wake", d < 3 ? 0 : 1, {29'h0, mode_out});
			wmode(3'h0);
			chk("run_state", 32'h2, {30'h0, run_state_out});
			@(posedge core_clk_in) irq <= 4'h0;
		end
		$display("test sleep done");
		wr(8'h04, 32'h1);
		for (int r = 0; r < 2; r++) begin
			wr(8'h00, 32'h280 | r << 2);
			go(1'b1, 1'b0);
			wmode(3'h2 + r);
			@(posedge core_clk_in);
			aw <= 8'h2;
			repeat (2) @(posedge core_clk_in);
			aw <= r ? 8'h0 : 8'h1;
			bk <= {4'h0, r[0]};
			#1 chk("masked", 3'h2 + r, {29'h0, mode_out});
			@(posedge core_clk_in);
			aw <= 8'h0;
			bk <= 5'h0;
			wmode(3'h0);
			chk("wake_irq", 32'h1, {31'h0, wake_irq_out});
			rd(8'h08, r ? 32'h100 : 32'h1);
			wr(8'h08, 32'h3ff);
			#1 chk("wake_irq_clr", 32'h0, {31'h0, wake_irq_out});
			chk("run_state", 32'h2, {30'h0, run_state_out});
		end
		$display("test wait done");
		for (int i = 0; i < 5; i++) begin
			wr(8'h00, 32'h2bc);
			go(1'b1, 1'b0);
			wmode(3'h4);
			chk("bkp_pins", 32'h1a, {io_hold_out, slow_xtal_en_out, slow_rc_en_out,
				slow_clock_source_select_out, core_power_on_out});
			@(posedge core_clk_in);
			core_supply_ok_in <= 1'b0;
			bk <= 5'h1 << i;
			@(posedge core_clk_in);
			bk <= 5'h0;
			repeat (3) @(posedge core_clk_in);
			#1 chk("core_up", 32'h17, {mode_out, core_reset_out, core_power_on_out});
			@(posedge core_clk_in);
			core_supply_ok_in <= 1'b1;
			wmode(3'h0);
			chk("run_state", 32'h2, {30'h0, run_state_out});
			rd(8'h10, 32'h1 << i);
			rd(8'h0c, 32'h20);
			wr(8'h10, 32'h1f);
			wr(8'h0c, 32'h3f);
		end
		$display("test backup wake done");
		for (int i = 0; i < 4; i++) begin
			wr(8'h00, 32'h2bc);
			go(1'b1, 1'b0);
			wmode(3'h4);
			@(posedge core_clk_in);
			rs <= 4'h1 << i;
			@(posedge core_clk_in);
			rs <= 4'h0;
			wmode(3'h0);
			chk("run_state", 32'h0, {30'h0, run_state_out});
			rd(8'h0c, 32'h2 << i);
			wr(8'h0c, 32'h3f);
		end
		$display("test backup reset done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
